// File: core/uts_status_fifo.v
// Transfer status queue with APB register access
`timescale 1ns/100ps
`default_nettype none
`include "uts_defines.vh"

module uts_status_fifo #(
    parameter DEPTH = `UTS_DEPTH
) (
    // Clock, reset and APB slave
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Transaction engine side
    input  wire        tokenDone,
    input  wire [3:0]  tokenEndpoint,
    input  wire        tokenTransmit,
    input  wire        tokenOddBank,
    // Status toward the engine and software
    output reg         pushReadyOut,
    output reg         token_done_flag,
    output reg         lostEntry
);

    // ==========================================================
    // Entry packing
    // Entry layout, most significant first: endpoint number (4 bits),
    // transmit direction, odd bank. The status word places these
    // fields at bits 7 to 2 so one shift covers the whole entry.
    function [`UTS_ENTRY_W-1:0] packEntry;
        input [3:0] ep;
        input       tx;
        input       odd;
        begin
            packEntry = {ep, tx, odd};
        end
    endfunction

    // Status word from an entry, unused bits forced to zero
    function [31:0] statusWord;
        input [`UTS_ENTRY_W-1:0] ent;
        begin
            statusWord = `UTS_WORD_ZERO;
            statusWord[`UTS_EP_HI:`UTS_EP_LO] = ent[5:2];
            statusWord[`UTS_DIR_BIT]  = ent[1];
            statusWord[`UTS_BANK_BIT] = ent[0];
        end
    endfunction

    // ==========================================================
    // Queue
    wire                    qReady;
    wire                    qNotEmpty;
    wire [`UTS_ENTRY_W-1:0] qHead;
    wire [2:0]              qLevel;
    wire                    popReq;
    wire                    pushReq;

    // The queue keeps pointers and occupancy; this level only decides
    // when to push and pop. A full queue refuses the push and the loss
    // marker records it, because the transaction engine has no way to
    // hold a finished token back.
    // Push request on every completed transfer; the queue checks for room
    assign pushReq = tokenDone;

    uts_entry_queue #(
        .WIDTH (`UTS_ENTRY_W),
        .DEPTH (DEPTH),
        .AW    (2)
    ) uQueue (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .pushValid (pushReq),
        .pushData  (packEntry(tokenEndpoint, tokenTransmit,
                              tokenOddBank)),
        .popReq    (popReq),
        .pushReady (qReady),
        .notEmpty  (qNotEmpty),
        .headData  (qHead),
        .level     (qLevel)
    );

    // ==========================================================
    // APB decode
    // Register map, one aligned word each:
    //   status  head entry, read only; writes are ignored
    //   flags   bit 3 token-done, bit 0 lost entry; write one to clear
    //   level   number of entries held, read only
    // Any other address answers with an error and has no effect.
    wire setupPhase;
    wire clearLost;
    wire apbAccess;
    wire apbWrite;
    wire hitStatus;
    wire hitFlags;
    wire hitLevel;
    wire clearDone;

    // Zero wait states: pready is high through every access phase
    assign apbAccess = psel && penable && pready;
    assign apbWrite  = apbAccess && pwrite;
    assign hitStatus = (paddr == `UTS_OFF_STATUS);
    assign hitFlags  = (paddr == `UTS_OFF_FLAGS);
    assign hitLevel  = (paddr == `UTS_OFF_LEVEL);

    // Write one to the token-done bit clears it and pops the head
    assign clearDone = apbWrite && hitFlags && pstrb[0] &&
                       pwdata[`UTS_TOKEN_DONE_BIT];
    // Pop only while the flag stands, so a stray clear never drops data
    assign popReq    = clearDone && token_done_flag;

    // Setup cycle of a transfer: the whole response is decided here
    assign setupPhase = psel && !penable;
    assign clearLost  = apbWrite && hitFlags && pstrb[0] && pwdata[0];

    // ==========================================================
    // Next values of the flag, loss marker and room indicator
    localparam [2:0] LAST_SLOT = DEPTH[2:0] - 3'd1;
    reg        flagNext;
    reg        lostNext;
    reg        roomNext;
    reg        readyNext;
    reg        errNext;
    reg [31:0] rdataNext;

    // Token-done flag follows queue occupancy. A pop drops it for one
    // cycle, then it rises again if entries remain, so software sees a
    // fresh edge per entry. A push in the pop cycle stays queued and
    // re-raises the flag on the next cycle, unless the queue was full, which refuses the push.
    always @* begin
        flagNext = qNotEmpty;
        if (popReq) begin
            flagNext = 1'b0;
        end
    end

    // Loss marker is sticky; a refused push wins over a clear in the
    // same cycle so that a loss is never hidden from software
    always @* begin
        lostNext = lostEntry;
        if (clearLost) begin
            lostNext = 1'b0;
        end
        if (tokenDone && !qReady) begin
            lostNext = 1'b1;
        end
    end

    // Room indicator is one cycle late, so it also drops when the push
    // being taken now fills the last slot
    always @* begin
        roomNext = qReady;
        if (tokenDone && qLevel == LAST_SLOT) begin
            roomNext = 1'b0;
        end
    end

    // Status registers toward software and the transaction engine
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            token_done_flag <= 1'b0;
            lostEntry       <= 1'b0;
            pushReadyOut    <= 1'b1;
        end else begin
            token_done_flag <= flagNext;
            lostEntry       <= lostNext;
            pushReadyOut    <= roomNext;
        end
    end

    // ==========================================================
    // APB response, decided in the setup cycle and registered so the
    // access phase always completes after exactly one cycle
    always @* begin
        readyNext = setupPhase;
        errNext   = setupPhase && !(hitStatus || hitFlags || hitLevel);
        rdataNext = `UTS_WORD_ZERO;
        if (setupPhase && !pwrite) begin
            if (hitStatus) begin
                // Head entry; undefined unless token-done is set
                rdataNext = statusWord(qHead);
            end else if (hitFlags) begin
                rdataNext[`UTS_TOKEN_DONE_BIT] = token_done_flag;
                rdataNext[0] = lostEntry;
            end else if (hitLevel) begin
                rdataNext[2:0] = qLevel;
            end
        end
    end

    // Read data returns to zero outside the access phase
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `UTS_WORD_ZERO;
        end else begin
            pready  <= readyNext;
            pslverr <= errNext;
            prdata  <= rdataNext;
        end
    end

endmodule

`default_nettype wire

// File: core/uts_defines.vh
// Register offsets, field positions and reset values of the transfer status queue
`ifndef UTS_DEFINES_VH
`define UTS_DEFINES_VH

// Register byte offsets
`define UTS_OFF_STATUS     12'h000
`define UTS_OFF_FLAGS      12'h004
`define UTS_OFF_LEVEL      12'h008

// Status register field positions
`define UTS_EP_HI          7
`define UTS_EP_LO          4
`define UTS_DIR_BIT        3
`define UTS_BANK_BIT       2

// Interrupt flag register field position
`define UTS_TOKEN_DONE_BIT 3

// Queue geometry and reset values
`define UTS_DEPTH          4
`define UTS_ENTRY_W        6
`define UTS_ENTRY_RST      6'h00
`define UTS_WORD_ZERO      32'h0000_0000

`endif

// File: core/uts_entry_queue.v
// Four-deep first-in first-out store of completed transfer records
`timescale 1ns/100ps
`default_nettype none
`include "uts_defines.vh"

module uts_entry_queue #(
    parameter WIDTH = `UTS_ENTRY_W,
    parameter DEPTH = `UTS_DEPTH,
    parameter AW    = 2
) (
    input  wire             clk_sys,
    input  wire             rst,
    input  wire             pushValid,
    input  wire [WIDTH-1:0] pushData,
    input  wire             popReq,
    output wire             pushReady,
    output wire             notEmpty,
    output wire [WIDTH-1:0] headData,
    output wire [AW:0]      level
);

    // ==========================================================
    // Storage and pointers
    reg [WIDTH-1:0] memArr [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_reg;
    reg [AW-1:0]    rdPtr_reg;
    reg [AW:0]      count_reg;
    wire            doPush;
    wire            doPop;

    assign pushReady = (count_reg != DEPTH[AW:0]);
    assign notEmpty  = (count_reg != {(AW+1){1'b0}});
    assign doPush    = pushValid && pushReady;
    assign doPop     = popReq && notEmpty;
    assign headData  = memArr[rdPtr_reg];
    assign level     = count_reg;

    // Write the entry; memory needs no reset, count guards its use
    always @(posedge clk_sys) begin
        if (doPush) begin
            memArr[wrPtr_reg] <= pushData;
        end
    end

    // Pointer and occupancy update; push and pop may share a cycle
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= {AW{1'b0}};
            rdPtr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (doPush) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doPop) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            if (doPush && !doPop) begin
                count_reg <= count_reg + 1'b1;
            end else if (doPop && !doPush) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// File: testbench/uts_status_fifo_checker.sv
// Port assertions for the transfer status queue
`timescale 1ns/100ps
`default_nettype none

module uts_status_fifo_checker (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        tokenDone,
    input wire logic        token_done_flag,
    input wire logic        lostEntry
);
    // =============
    // Properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Completing reads and pops, decoded once for several properties
    wire logic rdStat = pready && !pwrite && paddr == 12'h000;
    wire logic popNow = pready && pwrite && paddr == 12'h004 && pwdata[3];
    property p_hi; rdStat |-> prdata[31:8] == 24'h00_0000; endproperty
    a_hi: assert property (p_hi) else $error("status high bits set");
    property p_lo; rdStat |-> prdata[1:0] == 2'h0; endproperty
    a_lo: assert property (p_lo) else $error("status low bits set");
    property p_lvl; pready && paddr == 12'h008 |-> prdata <= 32'h4; endproperty
    a_lvl: assert property (p_lvl) else $error("level above depth");
    property p_pop; popNow && token_done_flag |=> !token_done_flag; endproperty
    a_pop: assert property (p_pop) else $error("pop kept flag");
    // A push with no pop for three cycles must leave the flag raised
    property p_set; tokenDone ##1 !psel [*3] |-> token_done_flag; endproperty
    a_set: assert property (p_set) else $error("flag not raised");
    property p_lost; $rose(lostEntry) |-> $past(tokenDone); endproperty
    a_lost: assert property (p_lost) else $error("loss without push");
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no answer after setup");
    property p_err; pready && paddr > 12'h008 |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
endmodule

bind uts_status_fifo uts_status_fifo_checker uts_status_fifo_checker_inst (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tokenDone, .token_done_flag, .lostEntry);
`default_nettype wire

// File: testbench/uts_token_engine.sv
// Transaction engine model pushing completed-token records
`timescale 1ns/100ps
`default_nettype none

module uts_token_engine (
    input  wire logic       clk_sys,
    input  wire logic       sendReq,
    input  wire logic [5:0] sendRec,
    output var  logic       tokenDone,
    output var  logic [5:0] tokenRec
);
    // =============
    // One pulse per record; data is inverted on every cycle after the pulse, so a
    // design that samples one cycle late never sees a stale but plausible record
    initial tokenDone = 1'h0;
    initial tokenRec = 6'h00;
    always @(posedge clk_sys) begin
        tokenDone <= sendReq;
        tokenRec  <= sendReq ? sendRec : ~tokenRec;
    end
endmodule
`default_nettype wire

// File: testbench/uts_status_fifo_test.sv
// Self-checking bench for the transfer status queue
`timescale 1ns/100ps
`default_nettype none
`include "uts_defines.vh"
`define CHK(n, e, s) begin totalChecks++; if ((s) !== (e)) begin \
    miscompares++; $display("mismatch %s exp %h got %h", n, e, s); end end

module uts_status_fifo_test;
    logic        clk_sys = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
    logic        pwrite = 1'h0, sendReq = 1'h0, pready, pslverr, lastErr;
    logic        tokenDone, pushReadyOut, token_done_flag, lostEntry;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic [5:0]  sendRec = 6'h00, tokenRec;
    int          miscompares = 0, totalChecks = 0, cycles = 0;
    // Rows of {endpoint, direction, bank}; the fifth meets a full queue
    logic [5:0]  rows [5] = '{6'h00, 6'h3F, 6'h2A, 6'h15, 6'h09};

    uts_status_fifo uts_status_fifo_inst (.clk_sys, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
        .tokenDone, .tokenEndpoint(tokenRec[5:2]), .tokenTransmit(tokenRec[1]),
        .tokenOddBank(tokenRec[0]), .pushReadyOut, .token_done_flag,
        .lostEntry);
    uts_token_engine uts_token_engine_inst (.clk_sys, .sendReq, .sendRec,
        .tokenDone, .tokenRec);

    // =============
    // Clock, hang limit and bus tasks
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (++cycles == 3000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // Request held until pready is seen; one idle cycle follows
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do @(posedge clk_sys); while (pready !== 1'h1);
        q = prdata;
        lastErr = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys);
    endtask
    task automatic push(input logic [5:0] r);
        sendReq <= 1'h1;
        sendRec <= r;
        @(posedge clk_sys);
        sendReq <= 1'h0;
        @(posedge clk_sys);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // =============
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        `CHK("flag", 1'h0, token_done_flag)
        `CHK("room", 1'h1, pushReadyOut)
        foreach (rows[i]) push(rows[i]);
        repeat (3) @(posedge clk_sys);
        `CHK("full", 1'h0, pushReadyOut)
        `CHK("lost", 1'h1, lostEntry)
        apb(1'h0, `UTS_OFF_LEVEL, 32'h0000_0000);
        `CHK("level", 32'h0000_0004, q)
        apb(1'h0, `UTS_OFF_FLAGS, 32'h0000_0000);
        `CHK("flags", 32'h0000_0009, q)
        // Drain in arrival order, popping by clearing the flag
        for (int i = 0; i < 4; i++) begin
            `CHK("tflag", 1'h1, token_done_flag)
            apb(1'h0, `UTS_OFF_STATUS, 32'h0000_0000);
            `CHK("status", {24'h00_0000, rows[i], 2'h0}, q)
            apb(1'h1, `UTS_OFF_FLAGS, 32'h0000_0008);
            @(posedge clk_sys);
        end
        `CHK("empty", 1'h0, token_done_flag)
        // A status write and a pop on an empty queue must change nothing; the flags write also clears the loss marker
        apb(1'h1, `UTS_OFF_STATUS, 32'hFFFF_FFFF);
        apb(1'h1, `UTS_OFF_FLAGS, 32'h0000_0009);
        apb(1'h0, `UTS_OFF_FLAGS, 32'h0000_0000);
        `CHK("cleared", 32'h0000_0000, q)
        apb(1'h0, 12'h00C, 32'h0000_0000);
        `CHK("unmapped", 1'h1, lastErr)
        push(rows[1]);
        // Status is read only once the flag says it is meaningful
        repeat (2) @(posedge clk_sys);
        `CHK("reflag", 1'h1, token_done_flag)
        apb(1'h0, `UTS_OFF_STATUS, 32'h0000_0000);
        `CHK("refill", {24'h00_0000, rows[1], 2'h0}, q)
        // Reset in mid-run empties the queue and drops the flag
        rst <= 1'h1;
        @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        `CHK("rstflag", 1'h0, token_done_flag)
        apb(1'h0, `UTS_OFF_LEVEL, 32'h0000_0000);
        `CHK("rstlevel", 32'h0000_0000, q)
        report_and_stop();
    end
endmodule
`default_nettype wire
